// ==== rtl/input_port_edge_interrupt.sv ====
/*
 * Four-pin input port with pull selection, pin-level readback and
 * per-pin edge interrupt requests, as an APB slave.
 * Assumes pins and the slow sample clock are asynchronous to pclk, and
 * stop_mode comes from power control logic on pclk. Masking and priority
 * of the requests live in the interrupt controller outside.
 */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module input_port_edge_interrupt #(
    parameter int NPINS = input_port_pkg::NPINS     // Number of port pins
) (
    input  wire logic                     pclk,             // System clock, 100 MHz
    input  wire logic                     presetn,          // Async reset, active low
    input  wire logic                     ce,               // Clock enable, freezes all
    input  wire input_port_pkg::apb_req_t apb_req,          // APB request group
    output input_port_pkg::apb_rsp_t      apb_rsp,          // APB answer group
    input  wire logic [NPINS-1:0]         input_pins,       // Port pins, asynchronous
    input  wire logic                     slow_sample_clock,// 16 kHz time-base tap
    input  wire logic                     stop_mode,        // Chip in stop mode
    output logic [NPINS-1:0]              pin_irq,          // Per-pin request pulses
    output logic [NPINS-1:0]              pull_up_en,       // Pull-up resistor enables
    output logic [NPINS-1:0]              pull_down_en,     // Pull-down resistor enables
    output logic                          pwm_event_a,      // Pin 0 to PWM event
    output logic                          pwm_event_b,      // Pin 1 to PWM event
    output logic                          uart_a_receive,   // Pin 2 to UART receive
    output logic                          uart_b_receive    // Pin 3 to UART receive
);

    // Synchronisers and sample tick
    logic [NPINS-1:0]         pin_meta;
    logic [NPINS-1:0]         pin_level_bits;
    logic                     slow_meta;
    logic                     slow_sync;
    logic                     slow_prev;
    logic                     sample_tick;
    logic                     slow_fall;

    // Software-visible control
    logic [3:0]               edge_mode_low_bits;
    logic [3:0]               edge_mode_high_bits;
    logic [3:0]               edge_sampling_select;
    logic [3:0]               input_mode_low_bits;
    logic [3:0]               input_mode_high_bits;

    // Bus slave
    input_port_pkg::apb_state_t state;
    input_port_pkg::apb_state_t next_state;
    logic [15:0]              reg_index;
    logic                     access;
    logic                     commit_write;
    logic [31:0]              read_value;
    logic                     read_hit;
    logic [NPINS-1:0]         edge_irq;
    logic                     wr_edge_low;
    logic                     wr_edge_high;
    logic                     wr_sample_sel;
    logic                     wr_mode_low;
    logic                     wr_mode_high;
    logic                     wr_mode_word;
    logic [31:0]              next_prdata;
    logic                     next_pready;
    logic                     next_pslverr;
    logic [NPINS-1:0]         next_pull_up;
    logic [NPINS-1:0]         next_pull_down;

    assign reg_index = apb_req.paddr[17:2];
    assign access    = apb_req.psel & apb_req.penable;

    // Two flops before any logic reads the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta       <= '0;
            pin_level_bits <= '0;
        end else if (ce) begin
            pin_meta       <= input_pins;
            pin_level_bits <= pin_meta;
        end
    end

    // Slow clock is a level from another domain; its falling edge is the tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_meta <= 1'b0;
            slow_sync <= 1'b0;
            slow_prev <= 1'b0;
        end else if (ce) begin
            slow_meta <= slow_sample_clock;
            slow_sync <= slow_meta;
            slow_prev <= slow_sync;
        end
    end

    assign slow_fall   = slow_prev & ~slow_sync;
    assign sample_tick = slow_fall & ~stop_mode;

    // APB state: answer one cycle into the access phase
    always_comb begin
        next_state = state;
        case (state)
            input_port_pkg::ST_IDLE: begin
                if (access) begin
                    next_state = input_port_pkg::ST_REPLY;
                end
            end
            input_port_pkg::ST_REPLY: begin
                next_state = input_port_pkg::ST_IDLE;
            end
            default: begin
                next_state = input_port_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= input_port_pkg::ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // The write lands at the edge where the master sees pready high
    assign commit_write = access & apb_req.pwrite & apb_rsp.pready;

    // One strobe per register keeps the update blocks free of decode
    assign wr_edge_low   = commit_write & (reg_index == input_port_pkg::IDX_EDGE_LOW);
    assign wr_edge_high  = commit_write & (reg_index == input_port_pkg::IDX_EDGE_HIGH);
    assign wr_sample_sel = commit_write & (reg_index == input_port_pkg::IDX_SAMPLE_SEL);
    assign wr_mode_low   = commit_write & (reg_index == input_port_pkg::IDX_MODE_LOW);
    assign wr_mode_high  = commit_write & (reg_index == input_port_pkg::IDX_MODE_HIGH);
    assign wr_mode_word  = commit_write & (reg_index == input_port_pkg::IDX_MODE_WORD);

    // Read mux; unused upper bits stay zero
    always_comb begin
        read_value = 32'h0000_0000;
        read_hit   = 1'b1;
        case (reg_index)
            input_port_pkg::IDX_EDGE_LOW: begin
                read_value[3:0] = edge_mode_low_bits;
            end
            input_port_pkg::IDX_EDGE_HIGH: begin
                read_value[3:0] = edge_mode_high_bits;
            end
            input_port_pkg::IDX_SAMPLE_SEL: begin
                read_value[3:0] = edge_sampling_select;
            end
            input_port_pkg::IDX_PIN_LEVEL: begin
                read_value[3:0] = pin_level_bits[3:0];
            end
            input_port_pkg::IDX_MODE_LOW: begin
                read_value[3:0] = input_mode_low_bits;
            end
            input_port_pkg::IDX_MODE_HIGH: begin
                read_value[3:0] = input_mode_high_bits;
            end
            input_port_pkg::IDX_MODE_WORD: begin
                // both mode bytes as a word
                read_value[3:0]   = input_mode_low_bits;
                read_value[11:8]  = input_mode_high_bits;
            end
            default: begin
                read_hit = 1'b0;
            end
        endcase
    end

    // Answer group registered; data captured as pready rises
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (state == input_port_pkg::ST_IDLE && access) begin
            next_prdata  = apb_req.pwrite ? 32'h0000_0000 : read_value;
            next_pready  = 1'b1;
            // Writes to the read-only level register are dropped quietly
            next_pslverr = ~read_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_rsp.prdata  <= 32'h0000_0000;
            apb_rsp.pready  <= 1'b0;
            apb_rsp.pslverr <= 1'b0;
        end else if (ce) begin
            apb_rsp.prdata  <= next_prdata;
            apb_rsp.pready  <= next_pready;
            apb_rsp.pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_mode_low_bits  <= input_port_pkg::RST_CTRL;
            edge_mode_high_bits <= input_port_pkg::RST_CTRL;
        end else if (ce) begin
            if (wr_edge_low) begin
                edge_mode_low_bits <= input_port_pkg::lane_merge(
                    edge_mode_low_bits, apb_req.pwdata[7:0], apb_req.pstrb[0]);
            end
            if (wr_edge_high) begin
                edge_mode_high_bits <= input_port_pkg::lane_merge(
                    edge_mode_high_bits, apb_req.pwdata[7:0], apb_req.pstrb[0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sampling_select <= input_port_pkg::RST_CTRL;
        end else if (ce) begin
            if (wr_sample_sel) begin
                edge_sampling_select <= input_port_pkg::lane_merge(
                    edge_sampling_select, apb_req.pwdata[7:0], apb_req.pstrb[0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_mode_low_bits  <= input_port_pkg::RST_CTRL;
            input_mode_high_bits <= input_port_pkg::RST_CTRL;
        end else if (ce) begin
            if (wr_mode_low || wr_mode_word) begin
                input_mode_low_bits  <= input_port_pkg::lane_merge(
                    input_mode_low_bits, apb_req.pwdata[7:0], apb_req.pstrb[0]);
            end
            if (wr_mode_high) begin
                input_mode_high_bits <= input_port_pkg::lane_merge(
                    input_mode_high_bits, apb_req.pwdata[7:0], apb_req.pstrb[0]);
            end
            // Word access puts the high byte on the second lane
            if (wr_mode_word) begin
                input_mode_high_bits <= input_port_pkg::lane_merge(
                    input_mode_high_bits, apb_req.pwdata[15:8], apb_req.pstrb[1]);
            end
        end
    end

    always_comb begin
        next_pull_up   = '0;
        next_pull_down = '0;
        for (int n = 0; n < NPINS; n++) begin
            {next_pull_up[n], next_pull_down[n]} = input_port_pkg::pull_decode(
                {input_mode_high_bits[n], input_mode_low_bits[n]});
        end
    end

    // Registered so the pad controls never see decode glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_up_en   <= '0;
            pull_down_en <= '0;
        end else if (ce) begin
            pull_up_en   <= next_pull_up;
            pull_down_en <= next_pull_down;
        end
    end

    // One detector per pin
    for (genvar g = 0; g < NPINS; g++) begin : g_pin
        edge_detect_unit u_edge (
            .pclk          (pclk),
            .presetn       (presetn),
            .ce            (ce),
            .level         (pin_level_bits[g]),
            .sample_tick   (sample_tick),
            .edge_mode     ({edge_mode_high_bits[g], edge_mode_low_bits[g]}),
            .sample_enable (edge_sampling_select[g]),
            .irq           (edge_irq[g])
        );
    end

    // request one edge after qualifying sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_irq <= '0;
        end else if (ce) begin
            pin_irq <= edge_irq;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_event_a    <= 1'b0;
            pwm_event_b    <= 1'b0;
            uart_a_receive <= 1'b0;
            uart_b_receive <= 1'b0;
        end else if (ce) begin
            pwm_event_a    <= pin_level_bits[0];
            pwm_event_b    <= pin_level_bits[1];
            uart_a_receive <= pin_level_bits[2];
            uart_b_receive <= pin_level_bits[3];
        end
    end

endmodule // input_port_edge_interrupt

// ==== rtl/input_port_pkg.sv ====
/*
 * Constants, encodings, bus carriers and shared helpers of the four-pin
 * edge-interrupt input port.
 * Assumes an APB master with 32-bit data and byte strobes. Each register
 * index sits at byte address four times the index.
 */
// Functional notes
// - Pin-level register returns the live level of pins 3..0, read-only, 1 means high.
// - Input-mode pairs decode: 00 hi-Z, 01 pull-down, 10 pull-up, 11 hi-Z.
// - Both input-mode registers clear at reset, so every pin starts hi-Z.
// - Input-mode registers also reachable together as one 16-bit word, low byte low.
// - Edge-mode pairs: 00 off, 01 falling, 10 rising, 11 both; reset zero.
// - Per-pin select bit: 0 unsampled edge detect, 1 sampled on 16 kHz tap.
// - In stop mode the sample clock halts, so no sampling happens at all.
// - A selected edge raises that pin's own separate interrupt request.
// - Requests are masked outside, in the separate interrupt controller.
// - Sampled rising mode: sample on slow clock falling edge, two highs qualify.
// - Sampled request follows the system clock edge after the second qualifying sample.
// - Pin 0,1 feed the PWM event inputs, pins 2,3 the UART receive inputs.
package input_port_pkg;

    localparam int          ADDR_W         = 18;
    localparam int          DATA_W         = 32;
    localparam int          NPINS          = 4;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_EDGE_LOW   = 16'hF020;
    localparam logic [15:0] IDX_EDGE_HIGH  = 16'hF021;
    localparam logic [15:0] IDX_SAMPLE_SEL = 16'hF022;
    localparam logic [15:0] IDX_PIN_LEVEL  = 16'hF204;
    localparam logic [15:0] IDX_MODE_LOW   = 16'hF206;
    localparam logic [15:0] IDX_MODE_HIGH  = 16'hF207;
    localparam logic [15:0] IDX_MODE_WORD  = 16'hF300;

    // Field layout: pin n sits at bit n of each byte register
    localparam int          FIELD_LSB      = 0;
    localparam int          WORD_HIGH_LSB  = 8;
    localparam logic [3:0]  RST_CTRL       = 4'h0;

    // Per-pin pair encodings {bit1, bit0}
    localparam logic [1:0]  EDGE_NONE      = 2'h0;
    localparam logic [1:0]  EDGE_FALL      = 2'h1;
    localparam logic [1:0]  EDGE_RISE      = 2'h2;
    localparam logic [1:0]  EDGE_BOTH      = 2'h3;
    localparam logic [1:0]  PULL_DOWN      = 2'h1;
    localparam logic [1:0]  PULL_UP        = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_REPLY = 2'b10
    } apb_state_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_t;

    // Returns {pull_up, pull_down}; both codes 00 and 11 leave the pin floating
    function automatic logic [1:0] pull_decode(input logic [1:0] sel);
        pull_decode = {sel == PULL_UP, sel == PULL_DOWN};
    endfunction

    // Byte-lane write of a 4-bit field; upper bits of the lane are dropped
    function automatic logic [3:0] lane_merge(input logic [3:0] old,
                                              input logic [7:0] lane,
                                              input logic       en);
        lane_merge = en ? lane[3:0] : old;
    endfunction

endpackage

// ==== rtl/edge_detect_unit.sv ====
/*
 * Edge detector of one input pin, unsampled and sampled paths.
 * Assumes level is already synchronised to pclk and sample_tick is a
 * one-cycle pulse on each falling edge of the slow sample clock.
 */
`timescale 1ns/1ps
module edge_detect_unit (
    input  wire logic       pclk,          // System clock
    input  wire logic       presetn,       // Async reset, active low
    input  wire logic       ce,            // Clock enable
    input  wire logic       level,         // Synchronised pin level
    input  wire logic       sample_tick,   // Slow clock falling edge pulse
    input  wire logic [1:0] edge_mode,     // Edge selection pair
    input  wire logic       sample_enable, // 1 selects sampled detection
    output logic            irq            // One-cycle request pulse
);
    logic prev;
    logic prev_valid;
    logic last_sample;
    logic have_sample;
    logic qual;
    logic qual_valid;
    logic u_rise;
    logic u_fall;
    logic s_rise;
    logic s_fall;
    logic rise;
    logic fall;

    // Unsampled path; first cycle after reset only primes the history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev       <= 1'b0;
            prev_valid <= 1'b0;
        end else if (ce) begin
            prev       <= level;
            prev_valid <= 1'b1;
        end
    end

    assign u_rise = prev_valid & level & ~prev;
    assign u_fall = prev_valid & ~level & prev;

    // Sampled path: qualified level moves only on two equal samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_sample <= 1'b0;
            have_sample <= 1'b0;
            qual        <= 1'b0;
            qual_valid  <= 1'b0;
        end else if (ce && sample_tick) begin
            last_sample <= level;
            have_sample <= 1'b1;
            if (have_sample && level == last_sample) begin
                qual       <= level;
                qual_valid <= 1'b1;
            end
        end
    end

    assign s_rise = sample_tick & have_sample & qual_valid & level & last_sample & ~qual;
    assign s_fall = sample_tick & have_sample & qual_valid & ~level & ~last_sample & qual;

    assign rise = sample_enable ? s_rise : u_rise;
    assign fall = sample_enable ? s_fall : u_fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            case (edge_mode)
                input_port_pkg::EDGE_FALL: irq <= fall;
                input_port_pkg::EDGE_RISE: irq <= rise;
                input_port_pkg::EDGE_BOTH: irq <= rise | fall;
                default:                   irq <= 1'b0;
            endcase
        end
    end

endmodule // edge_detect_unit

// ==== verif/input_port_monitor.sv ====
/* Concurrent checks on the port block's APB answer, pin routes and requests.
   Assumes ce stays high and the bench holds each pin level for several cycles. */
`timescale 1ns/1ps
module input_port_monitor #(
    parameter int NPINS = 4
) (
    input wire logic                     pclk,              // System clock
    input wire logic                     presetn,           // Reset, active low
    input wire logic                     ce,                // Clock enable
    input wire input_port_pkg::apb_req_t apb_req,           // APB request
    input wire input_port_pkg::apb_rsp_t apb_rsp,           // APB answer
    input wire logic [NPINS-1:0]         input_pins,        // Pins
    input wire logic                     slow_sample_clock, // Slow clock
    input wire logic                     stop_mode,         // Stop mode
    input wire logic [NPINS-1:0]         pin_irq,           // Requests
    input wire logic [NPINS-1:0]         pull_up_en,        // Pull-ups
    input wire logic [NPINS-1:0]         pull_down_en,      // Pull-downs
    input wire logic                     pwm_event_a,       // Pin 0 route
    input wire logic                     pwm_event_b,       // Pin 1 route
    input wire logic                     uart_a_receive,    // Pin 2 route
    input wire logic                     uart_b_receive     // Pin 3 route
);
    logic [2:0]  settle;
    logic [15:0] idx;
    logic        mapped;

    assign idx    = apb_req.paddr[17:2];
    assign mapped = idx inside {input_port_pkg::IDX_EDGE_LOW, input_port_pkg::IDX_EDGE_HIGH,
        input_port_pkg::IDX_SAMPLE_SEL, input_port_pkg::IDX_PIN_LEVEL,
        input_port_pkg::IDX_MODE_LOW, input_port_pkg::IDX_MODE_HIGH,
        input_port_pkg::IDX_MODE_WORD};

    // Pipelines still hold reset values for a few cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle <= 3'h0;
        end else if (ce && settle != 3'h7) begin
            settle <= settle + 3'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_timely_a: assert property (apb_req.psel && apb_req.penable
        && !$past(apb_req.penable) |-> !apb_rsp.pready ##1 apb_rsp.pready)
        else $error("pready late or early");
    ready_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    rdata_idle_a: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
        else $error("prdata not zero outside answer");
    err_unmapped_a: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped)
        else $error("pslverr does not match address map");
    err_ready_a: assert property (apb_rsp.pslverr
        |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
        else $error("pslverr without pready or with data");
    upper_zero_a: assert property (apb_rsp.pready && !apb_req.pwrite
        |-> apb_rsp.prdata[31:12] == 20'h0 && apb_rsp.prdata[7:4] == 4'h0)
        else $error("unused read bits not zero");
    pull_excl_a: assert property ((pull_up_en & pull_down_en) == '0)
        else $error("pull-up and pull-down both on");
    route_follow_a: assert property (settle == 3'h7
        |-> {uart_b_receive, uart_a_receive, pwm_event_b, pwm_event_a} == $past(input_pins[3:0], 3))
        else $error("routed pins do not follow");
    irq_cause_a: assert property (settle == 3'h7 && pin_irq != '0
        |-> $past(input_pins, 3) != $past(input_pins, 6)
            || ($past(slow_sample_clock, 7) && !$past(slow_sample_clock, 3)
                && !$past(stop_mode, 2)))
        else $error("request without pin edge or sample tick");
endmodule // input_port_monitor

// ==== verif/pin_source.sv ====
/* Pin and slow sample clock source for the port block.
   Assumes tasks are called from one bench process at a time. */
`timescale 1ns/1ps
module pin_source (
    input  wire logic       pclk,     // System clock
    output logic      [3:0] pins,     // Pin levels
    output logic            slow_clk  // Slow sample clock, idles low
);
    initial begin
        pins     = 4'h0;
        slow_clk = 1'b0;
    end

    // Level stands long enough for the synchroniser and request
    task automatic set_pin(input int n, input logic v);
        @(posedge pclk);
        pins[n] <= v;
        repeat (8) @(posedge pclk);
    endtask

    // Shortened period; the design only needs the falling edge
    task automatic tick();
        @(posedge pclk);
        slow_clk <= 1'b1;
        repeat (10) @(posedge pclk);
        slow_clk <= 1'b0;
        repeat (10) @(posedge pclk);
    endtask
endmodule // pin_source

// ==== verif/test_input_port_edge_interrupt.sv ====
/* Register, pull, route and edge request tests of the port block.
   Assumes the monitor is bound below and pin_source drives the pins. */
`timescale 1ns/1ps
module test_input_port_edge_interrupt;
    localparam int NPINS = 4;
    input_port_pkg::apb_req_t req;
    input_port_pkg::apb_rsp_t rsp;
    logic                     pclk, presetn, stop_mode, slow, er;
    logic                     ev_a, ev_b, rx_a, rx_b;
    logic [3:0]               pins, irq, pu, pd;
    logic [31:0]              rd;
    int                       n_errors, check_count, cnt, base;

    always #5 pclk = ~pclk;
    always @(posedge pclk) cnt <= cnt + int'(irq[2]);

    pin_source i_src (.pclk(pclk), .pins(pins), .slow_clk(slow));

    input_port_edge_interrupt #(.NPINS(NPINS)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .apb_req(req), .apb_rsp(rsp),
        .input_pins(pins), .slow_sample_clock(slow), .stop_mode(stop_mode), .pin_irq(irq),
        .pull_up_en(pu), .pull_down_en(pd), .pwm_event_a(ev_a), .pwm_event_b(ev_b),
        .uart_a_receive(rx_a), .uart_b_receive(rx_b));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, {idx, 2'b00}, d, s};
        @(posedge pclk);
        req.penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (rsp.pready === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++;
            results();
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, 4'h0);
        check(rd, exp);
    endtask

    initial begin
        pclk = 1'b0; presetn = 1'b0; stop_mode = 1'b0; req = '0;
        n_errors = 0; check_count = 0; cnt = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(input_port_pkg::IDX_EDGE_LOW, 32'h0);
        rdchk(input_port_pkg::IDX_EDGE_HIGH, 32'h0);
        rdchk(input_port_pkg::IDX_SAMPLE_SEL, 32'h0);
        rdchk(input_port_pkg::IDX_MODE_WORD, 32'h0);
        // Pins 0..3 get codes 00, 01, 10, 11
        apb(1'b1, input_port_pkg::IDX_MODE_WORD, 32'h0000FCFA, 4'h3);
        rdchk(input_port_pkg::IDX_MODE_WORD, 32'h00000C0A);
        rdchk(input_port_pkg::IDX_MODE_LOW, 32'h0000000A);
        check(32'({pu, pd}), 32'h00000042);
        apb(1'b1, input_port_pkg::IDX_MODE_HIGH, 32'h00000003, 4'h0);
        rdchk(input_port_pkg::IDX_MODE_HIGH, 32'h0000000C);
        apb(1'b1, input_port_pkg::IDX_MODE_WORD, 32'h00000300, 4'h2);
        rdchk(input_port_pkg::IDX_MODE_WORD, 32'h0000030A);
        rdchk(16'h0001, 32'h0);
        check(32'(er), 32'h1);
        i_src.set_pin(2, 1'b1);
        apb(1'b1, input_port_pkg::IDX_PIN_LEVEL, 32'h0000000F, 4'h1);
        rdchk(input_port_pkg::IDX_PIN_LEVEL, 32'h00000004);
        check(32'({rx_b, rx_a, ev_b, ev_a}), 32'h00000004);
        i_src.set_pin(2, 1'b0);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, input_port_pkg::IDX_EDGE_LOW, 32'(m % 2) << 2, 4'h1);
            apb(1'b1, input_port_pkg::IDX_EDGE_HIGH, 32'(m / 2) << 2, 4'h1);
            base = cnt;
            i_src.set_pin(2, 1'b1);
            check(32'(cnt - base), 32'(m / 2));
            i_src.set_pin(2, 1'b0);
            check(32'(cnt - base), 32'(m / 2 + m % 2));
        end
        // Sampled mode on pin 2: rising, then both edges, then stop mode
        apb(1'b1, input_port_pkg::IDX_SAMPLE_SEL, 32'h4, 4'h1);
        apb(1'b1, input_port_pkg::IDX_EDGE_LOW, 32'h0, 4'h1);
        base = cnt;
        i_src.tick();
        i_src.tick();
        i_src.set_pin(2, 1'b1);
        check(32'(cnt - base), 32'h0);
        i_src.tick();
        check(32'(cnt - base), 32'h0);
        i_src.tick();
        check(32'(cnt - base), 32'h1);
        apb(1'b1, input_port_pkg::IDX_EDGE_LOW, 32'h4, 4'h1);
        i_src.set_pin(2, 1'b0);
        i_src.tick();
        i_src.tick();
        check(32'(cnt - base), 32'h2);
        stop_mode <= 1'b1;
        i_src.set_pin(2, 1'b1);
        i_src.tick();
        i_src.tick();
        check(32'(cnt - base), 32'h2);
        results();
    end
endmodule // test_input_port_edge_interrupt

bind input_port_edge_interrupt input_port_monitor #(.NPINS(NPINS)) i_mon (
    .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .input_pins(input_pins), .slow_sample_clock(slow_sample_clock), .stop_mode(stop_mode),
    .pin_irq(pin_irq), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .pwm_event_a(pwm_event_a), .pwm_event_b(pwm_event_b),
    .uart_a_receive(uart_a_receive), .uart_b_receive(uart_b_receive));
